// file: core/tmr2_pkg.sv
// Package of register map, field layout and mode codes for timer two
package tmr2_pkg;

  // Data-space offsets (load/store access)
  localparam logic [7:0] TMR2_OFS_FLAGS    = 8'h37;
  localparam logic [7:0] TMR2_OFS_MASK     = 8'h70;
  localparam logic [7:0] TMR2_OFS_CTRL1    = 8'hb0;
  localparam logic [7:0] TMR2_OFS_CTRL2    = 8'hb1;
  localparam logic [7:0] TMR2_OFS_COUNT    = 8'hb2;
  localparam logic [7:0] TMR2_OFS_CMP_A    = 8'hb3;
  localparam logic [7:0] TMR2_OFS_CMP_B    = 8'hb4;
  // I/O-space offset reduction for the dedicated I/O instructions
  localparam logic [7:0] TMR2_IO_SHIFT     = 8'h20;

  // Reset values
  localparam logic [7:0] TMR2_RST_BYTE     = 8'h00;

  // Field positions in the second control register
  localparam int TMR2_BIT_FORCE_A          = 7;
  localparam int TMR2_BIT_FORCE_B          = 6;
  localparam int TMR2_BIT_WAVE_HIGH        = 3;
  // Field positions in the first control register
  localparam int TMR2_POS_MODE_A           = 6;
  localparam int TMR2_POS_MODE_B           = 4;
  // Flag and mask bit positions
  localparam int TMR2_BIT_OVF              = 0;
  localparam int TMR2_BIT_MATCH_A          = 1;
  localparam int TMR2_BIT_MATCH_B          = 2;

  // Counter limits
  localparam logic [7:0] TMR2_BOTTOM       = 8'h00;
  localparam logic [7:0] TMR2_MAX          = 8'hff;

  // Prescaler taps (divide ratio minus one, on a 10-bit prescaler)
  localparam logic [9:0] TMR2_DIV8_M1      = 10'h007;
  localparam logic [9:0] TMR2_DIV32_M1     = 10'h01f;
  localparam logic [9:0] TMR2_DIV64_M1     = 10'h03f;
  localparam logic [9:0] TMR2_DIV128_M1    = 10'h07f;
  localparam logic [9:0] TMR2_DIV256_M1    = 10'h0ff;
  localparam logic [9:0] TMR2_DIV1024_M1   = 10'h3ff;

  // Waveform mode codes {high bit, low bits}
  localparam logic [2:0] TMR2_WM_NORMAL    = 3'h0;
  localparam logic [2:0] TMR2_WM_PC_FF     = 3'h1;
  localparam logic [2:0] TMR2_WM_CLR_MATCH = 3'h2;
  localparam logic [2:0] TMR2_WM_FAST_FF   = 3'h3;
  localparam logic [2:0] TMR2_WM_PC_A      = 3'h5;
  localparam logic [2:0] TMR2_WM_FAST_A    = 3'h7;

  // Compare output mode codes
  localparam logic [1:0] TMR2_COM_OFF      = 2'h0;
  localparam logic [1:0] TMR2_COM_TOGGLE   = 2'h1;
  localparam logic [1:0] TMR2_COM_CLEAR    = 2'h2;
  localparam logic [1:0] TMR2_COM_SET      = 2'h3;

  // Count direction for phase-correct modes
  typedef enum logic {TMR2_UP, TMR2_DOWN} tmr2_dir_t;

endpackage : tmr2_pkg

// file: core/tmr2_prescaler.sv
// Prescaler producing one-cycle count enables from the I/O clock
`timescale 1ns/1ps
module tmr2_prescaler
  import tmr2_pkg::*;
#(
  parameter int PRE_W = 10                 // Prescaler width
)(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic [2:0] clock_select_field,
  // Count enable
  output logic            count_tick
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;                 // Free-running divider
  } tmr2_pre_state_t;

  tmr2_pre_state_t st_ff;                  // Registered state
  tmr2_pre_state_t nxt_st;                 // Next state
  logic [PRE_W-1:0] tap_mask;              // Low bits that must all be one

  ////////////////////////////////////////////////////////////////////////
  // Tap selection; one pulse each time the low bits wrap
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.cnt = st_ff.cnt + 1'b1;
    case (clock_select_field)              // RQ7
      3'h2:    tap_mask = TMR2_DIV8_M1;
      3'h3:    tap_mask = TMR2_DIV32_M1;
      3'h4:    tap_mask = TMR2_DIV64_M1;
      3'h5:    tap_mask = TMR2_DIV128_M1;
      3'h6:    tap_mask = TMR2_DIV256_M1;
      3'h7:    tap_mask = TMR2_DIV1024_M1;
      default: tap_mask = '0;
    endcase
    // Stopped when no source is selected; divide by one ticks every edge
    count_tick = (clock_select_field != 3'h0) &&
                 ((st_ff.cnt & tap_mask) == tap_mask); // RQ20
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

endmodule : tmr2_prescaler

// file: core/tmr2_timer.sv
// Timer two: counter, compare channels, force strobes and irq flags
//
// Summary of operation
// RQ1 - Force bits act only in non-PWM modes
// RQ2 - Software writes force zero in PWM modes
// RQ3 - Force strobe forces match on channel output
// RQ4 - Force is a strobe using current mode
// RQ5 - Forced match sets no flag, no clear
// RQ6 - Force bits always read as zero
// RQ7 - Clock select: stop or divide 1..1024
// RQ8 - Counter register readable and writable directly
// RQ9 - Counter write blocks match next tick
// RQ10 - Skipped matches after counter write are lost
// RQ11 - Compare registers matched continuously against counter
// RQ12 - Match irq needs mask, global, flag
// RQ13 - Overflow irq needs mask, global, flag
// RQ14 - Channel B flag set on B match
// RQ15 - Vector execution clears channel B flag
// RQ16 - Write one clears B flag, zero keeps
// RQ17 - Flag register also decodes at 0x17
// RQ18 - Overflow at max, or bottom turn-around; mode 7 sets the overflow flag at top (compare A) instead
// RQ19 - Mode bits select four modes, two tops
// RQ20 - Counter advances only on prescaler enables
`timescale 1ns/1ps
module tmr2_timer
  import tmr2_pkg::*;
#(
  parameter int CNT_W = 8                  // Counter width
)(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Register port: data-space load/store and I/O-instruction access
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_io_space,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_hit,
  // Processor side
  input  wire logic             cpu_status_word_i,
  input  wire logic [2:0]       vector_ack,
  output logic      [2:0]       irq_req,
  // Waveform outputs
  output logic                  wave_out_a,
  output logic                  wave_out_b
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]       output_mode_chan_a;  // Channel A output mode
    logic [1:0]       output_mode_chan_b;  // Channel B output mode
    logic [1:0]       wave_mode_low_bits;  // Low mode bits
    logic             wave_mode_high_bit;  // High mode bit
    logic [2:0]       clock_select_field;  // Prescaler choice
    logic [CNT_W-1:0] count;               // Counter value
    logic [CNT_W-1:0] cmp_a;               // Compare value A
    logic [CNT_W-1:0] cmp_b;               // Compare value B
    logic [2:0]       mask;                // Irq mask bits
    logic [2:0]       flags;               // Irq flags
    logic             blk_match;           // Match blocked for next tick
    tmr2_dir_t        dir;                 // Phase-correct direction
    logic             out_a;               // Waveform A level
    logic             out_b;               // Waveform B level
    logic [7:0]       rdata;               // Read data register
  } tmr2_state_t;

  tmr2_state_t st_ff;                      // Registered state
  tmr2_state_t nxt_st;                     // Next state

  logic             tick;                  // Count enable
  logic [2:0]       wmode;                 // Full waveform mode
  logic             pwm;                   // Any PWM mode
  logic             pc_mode;               // Phase-correct mode
  logic             fast_mode;             // Fast PWM mode
  logic [CNT_W-1:0] top;                   // Current top value
  logic [7:0]       eff_addr;              // Data-space equivalent address
  logic             wr_count;              // Counter write this cycle
  logic             hit_a;                 // Real match channel A
  logic             hit_b;                 // Real match channel B
  logic             frc_a;                 // Forced match channel A
  logic             frc_b;                 // Forced match channel B
  logic [2:0]       set_f;                 // Flag set events
  logic [2:0]       clr_f;                 // Flag clear events
  logic [CNT_W-1:0] cnt_next;              // Counter after a tick

  ////////////////////////////////////////////////////////////////////////
  // Prescaler
  tmr2_prescaler u_pre (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .clock_select_field (st_ff.clock_select_field),
    .count_tick         (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output-mode action on a match; used for real and forced matches
  function automatic logic apply_mode(input logic [1:0] md,
                                      input logic       lvl,
                                      input logic       down);
    logic r;
    r = lvl;
    case (md)
      TMR2_COM_TOGGLE: r = ~lvl;
      TMR2_COM_CLEAR:  r = down;
      TMR2_COM_SET:    r = ~down;
      default:         r = lvl;
    endcase
    return r;
  endfunction : apply_mode

  ////////////////////////////////////////////////////////////////////////
  // Mode decode, address decode and next state
  always_comb
  begin
    nxt_st    = st_ff;
    wmode     = {st_ff.wave_mode_high_bit, st_ff.wave_mode_low_bits};
    // Mode 3 and 7 fast, 1 and 5 phase-correct
    fast_mode = (wmode == TMR2_WM_FAST_FF) || (wmode == TMR2_WM_FAST_A);
    pc_mode   = (wmode == TMR2_WM_PC_FF) || (wmode == TMR2_WM_PC_A); // RQ19
    pwm       = fast_mode || pc_mode;
    top       = ((wmode == TMR2_WM_CLR_MATCH) || (wmode == TMR2_WM_PC_A) ||
                 (wmode == TMR2_WM_FAST_A)) ? st_ff.cmp_a : TMR2_MAX; // RQ19
    // I/O instructions address the flag register 0x20 lower
    eff_addr  = reg_io_space ? (reg_addr + TMR2_IO_SHIFT) : reg_addr; // RQ17
    reg_hit   = (eff_addr == TMR2_OFS_FLAGS) ||
                (!reg_io_space && ((eff_addr == TMR2_OFS_MASK) ||
                 ((eff_addr >= TMR2_OFS_CTRL1) &&
                  (eff_addr <= TMR2_OFS_CMP_B))));
    wr_count  = reg_wr && reg_hit && (eff_addr == TMR2_OFS_COUNT);
    // Strobes only exist in non-PWM modes
    frc_a = reg_wr && reg_hit && (eff_addr == TMR2_OFS_CTRL2) &&
            reg_wdata[TMR2_BIT_FORCE_A] && !pwm; // RQ1
    frc_b = reg_wr && reg_hit && (eff_addr == TMR2_OFS_CTRL2) &&
            reg_wdata[TMR2_BIT_FORCE_B] && !pwm; // RQ1
    // Compare is continuous but only acts on a tick and not when blocked
    hit_a = tick && !st_ff.blk_match && (st_ff.count == st_ff.cmp_a); // RQ11
    hit_b = tick && !st_ff.blk_match && (st_ff.count == st_ff.cmp_b); // RQ11
    set_f = '0;
    set_f[TMR2_BIT_MATCH_A] = hit_a;       // RQ18
    set_f[TMR2_BIT_MATCH_B] = hit_b;       // RQ14
    // Next count and overflow
    cnt_next = st_ff.count;
    if (pc_mode)
    begin
      if (st_ff.dir == TMR2_UP)
        cnt_next = (st_ff.count == top) ? st_ff.count - 1'b1
                                        : st_ff.count + 1'b1;
      else
        cnt_next = (st_ff.count == TMR2_BOTTOM) ? st_ff.count + 1'b1
                                                : st_ff.count - 1'b1;
      // Overflow when turning round at bottom
      set_f[TMR2_BIT_OVF] = tick && (st_ff.dir == TMR2_DOWN) &&
                            (st_ff.count == TMR2_BOTTOM); // RQ18
    end
    else
    begin
      cnt_next = (st_ff.count == top) ? TMR2_BOTTOM : st_ff.count + 1'b1;
      // Mode 7 flags at top, others at max
      set_f[TMR2_BIT_OVF] = tick && (wmode == TMR2_WM_FAST_A ?
                            (st_ff.count == top) :
                            (st_ff.count == TMR2_MAX)); // RQ18
    end
    if (tick)
    begin
      nxt_st.count     = cnt_next;         // RQ20
      nxt_st.blk_match = 1'b0;
      if (pc_mode && (st_ff.count == top))
        nxt_st.dir = TMR2_DOWN;
      else if (pc_mode && (st_ff.count == TMR2_BOTTOM))
        nxt_st.dir = TMR2_UP;
    end
    // Waveform A: real matches, fast-PWM bottom, forced strobes
    if (hit_a)
      nxt_st.out_a = apply_mode(st_ff.output_mode_chan_a, st_ff.out_a,
                                pc_mode && (st_ff.dir == TMR2_DOWN));
    else if (frc_a)
      nxt_st.out_a = apply_mode(st_ff.output_mode_chan_a, st_ff.out_a,
                                1'b0);  // RQ3 RQ4
    if (fast_mode && tick && (cnt_next == TMR2_BOTTOM) &&
        st_ff.output_mode_chan_a[1])
      nxt_st.out_a = ~st_ff.output_mode_chan_a[0];
    // Waveform B follows the same scheme
    if (hit_b)
      nxt_st.out_b = apply_mode(st_ff.output_mode_chan_b, st_ff.out_b,
                                pc_mode && (st_ff.dir == TMR2_DOWN));
    else if (frc_b)
      nxt_st.out_b = apply_mode(st_ff.output_mode_chan_b, st_ff.out_b,
                                1'b0);  // RQ3 RQ4
    if (fast_mode && tick && (cnt_next == TMR2_BOTTOM) &&
        st_ff.output_mode_chan_b[1])
      nxt_st.out_b = ~st_ff.output_mode_chan_b[0];
    // Forced strobes touch neither flags nor counter: frc_* feed no set_f
    // and the counter only clears through a real top match      // RQ5
    // Flag clears from write-one or vector execution
    clr_f = vector_ack;                    // RQ15
    if (reg_wr && reg_hit && (eff_addr == TMR2_OFS_FLAGS))
      clr_f = clr_f | reg_wdata[2:0];      // RQ16
    // A set arriving with its clear wins
    nxt_st.flags = (st_ff.flags & ~clr_f) | set_f;
    // Register writes
    if (reg_wr && reg_hit)
    begin
      case (eff_addr)
        TMR2_OFS_MASK:  nxt_st.mask = reg_wdata[2:0];
        TMR2_OFS_CTRL1:
        begin
          nxt_st.output_mode_chan_a = reg_wdata[TMR2_POS_MODE_A +: 2];
          nxt_st.output_mode_chan_b = reg_wdata[TMR2_POS_MODE_B +: 2];
          nxt_st.wave_mode_low_bits = reg_wdata[1:0];
        end
        TMR2_OFS_CTRL2:
        begin
          nxt_st.wave_mode_high_bit = reg_wdata[TMR2_BIT_WAVE_HIGH];
          nxt_st.clock_select_field = reg_wdata[2:0]; // RQ7
        end
        TMR2_OFS_COUNT:
        begin
          // Write overrides the tick; missed matches are not replayed
          nxt_st.count     = reg_wdata;    // RQ8 RQ10
          nxt_st.blk_match = wr_count;     // RQ9
          nxt_st.dir       = st_ff.dir;
        end
        TMR2_OFS_CMP_A: nxt_st.cmp_a = reg_wdata;
        TMR2_OFS_CMP_B: nxt_st.cmp_b = reg_wdata;
        default:        nxt_st.rdata = st_ff.rdata;
      endcase
    end
    // Read data, registered one cycle after the request
    if (reg_rd && reg_hit)
    begin
      case (eff_addr)
        TMR2_OFS_FLAGS: nxt_st.rdata = {5'h00, st_ff.flags};
        TMR2_OFS_MASK:  nxt_st.rdata = {5'h00, st_ff.mask};
        TMR2_OFS_CTRL1: nxt_st.rdata = {st_ff.output_mode_chan_a,
                                        st_ff.output_mode_chan_b, 2'h0,
                                        st_ff.wave_mode_low_bits};
        // Force bits never read back
        TMR2_OFS_CTRL2: nxt_st.rdata = {4'h0, st_ff.wave_mode_high_bit,
                                        st_ff.clock_select_field}; // RQ6
        TMR2_OFS_COUNT: nxt_st.rdata = st_ff.count;
        TMR2_OFS_CMP_A: nxt_st.rdata = st_ff.cmp_a;
        TMR2_OFS_CMP_B: nxt_st.rdata = st_ff.cmp_b;
        default:        nxt_st.rdata = TMR2_RST_BYTE;
      endcase
    end
    else if (reg_rd)
      nxt_st.rdata = TMR2_RST_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; irq needs global enable, mask and flag together
  assign irq_req    = st_ff.flags & st_ff.mask &
                      {3{cpu_status_word_i}}; // RQ12 RQ13
  assign reg_rdata  = st_ff.rdata;
  assign wave_out_a = st_ff.out_a;
  assign wave_out_b = st_ff.out_b;

endmodule : tmr2_timer

// file: sim/tmr2_timer_props.sv
// Checker of decode, read data, interrupt gating and force strobes
`timescale 1ns/1ps
module tmr2_timer_props
  import tmr2_pkg::*;
#(
  parameter int CNT_W = 8                // Counter width, kept in step
)(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_io_space,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  // Processor side
  input wire logic       cpu_status_word_i,
  input wire logic [2:0] vector_ack,
  input wire logic [2:0] irq_req,
  // Waveform outputs
  input wire logic       wave_out_a,
  input wire logic       wave_out_b
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  localparam logic [7:0] IO_FLAGS = TMR2_OFS_FLAGS - TMR2_IO_SHIFT;
  logic       map_hit;    // Address is one of the data-space registers
  logic       wr_c2;      // Write to control two
  logic       wr_flags;   // Write to the flag register, either space
  logic       stop;       // Timer clock off now and last cycle
  logic [2:0] cs_ff;      // Shadow of the clock select field
  logic       was_off_ff; // Clock select was zero last cycle
  logic       pwm_ff;     // Shadow of the low mode bit that marks PWM
  assign map_hit  = reg_addr inside {TMR2_OFS_FLAGS, TMR2_OFS_MASK,
                    TMR2_OFS_CTRL1, TMR2_OFS_CTRL2, TMR2_OFS_COUNT,
                    TMR2_OFS_CMP_A, TMR2_OFS_CMP_B};
  assign wr_c2    = reg_wr && reg_hit && !reg_io_space
                    && reg_addr == TMR2_OFS_CTRL2;
  assign wr_flags = reg_wr && reg_hit
                    && (reg_io_space || reg_addr == TMR2_OFS_FLAGS);
  // Two idle cycles so a late prescaler tick cannot spoil a check
  assign stop     = cs_ff == 3'h0 && was_off_ff;
  // Shadow the control fields from the write traffic
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cs_ff      <= 3'h0;
      was_off_ff <= 1'b1;
      pwm_ff     <= 1'b0;
    end
    else
    begin
      was_off_ff <= cs_ff == 3'h0;
      if (wr_c2)
        cs_ff <= reg_wdata[2:0];
      if (reg_wr && reg_hit && !reg_io_space && reg_addr == TMR2_OFS_CTRL1)
        pwm_ff <= reg_wdata[0];
    end
  end
  ////////////////////////////////////////
  a_hit_decode: assert property (
    reg_hit == (reg_io_space ? reg_addr == IO_FLAGS : map_hit))
    else $error("register decode wrong");
  a_unmapped_zero: assert property (
    reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_force_reads_zero: assert property (
    reg_rd && reg_hit && !reg_io_space && reg_addr == TMR2_OFS_CTRL2
    |=> reg_rdata[7:6] == 2'h0)
    else $error("force bits read back set");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_irq_global_gate: assert property (
    irq_req != 3'h0 |-> cpu_status_word_i)
    else $error("interrupt without global enable");
  a_mask_zero_gate: assert property (
    reg_wr && reg_hit && !reg_io_space && reg_addr == TMR2_OFS_MASK
    && reg_wdata[2:0] == 3'h0 |=> irq_req == 3'h0)
    else $error("interrupt with mask cleared");
  a_ack_clears_b: assert property (
    vector_ack[2] && stop |=> !irq_req[2])
    else $error("vector did not clear match b");
  a_w1c_clears_b: assert property (
    wr_flags && reg_wdata[2] && stop |=> !irq_req[2])
    else $error("write one did not clear match b");
  a_force_no_flag: assert property (
    wr_c2 && stop && reg_wdata[2:0] == 3'h0 && vector_ack == 3'h0
    |=> $stable(irq_req) || $changed(cpu_status_word_i))
    else $error("force strobe moved an interrupt");
  a_force_pwm_idle: assert property (
    wr_c2 && stop && pwm_ff && reg_wdata[2:0] == 3'h0 && reg_wdata[7:6] != 2'h0
    |=> $stable({wave_out_a, wave_out_b}) [*2])
    else $error("force acted in a PWM mode");
endmodule : tmr2_timer_props

bind tmr2_timer tmr2_timer_props #(.CNT_W(CNT_W)) u_props (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_io_space(reg_io_space), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .cpu_status_word_i(cpu_status_word_i), .vector_ack(vector_ack),
  .irq_req(irq_req), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));

// file: sim/tmr2_timer_tb_top.sv
// Self-checking bench for the timer two register block
`timescale 1ns/1ps
module tmr2_timer_tb_top
  import tmr2_pkg::*;
  ;
  // Row of the register table: space, address, write, expected read
  typedef struct packed {
    logic       io;
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] rd_exp;
  } tmr2_row_t;
  // Io row last: a write there must not reach the mask
  localparam tmr2_row_t ROWS [7] = '{'{1'b0, 8'h70, 8'h05, 8'h05},
    '{1'b0, 8'hb3, 8'h5a, 8'h5a}, '{1'b0, 8'hb4, 8'ha5, 8'ha5},
    '{1'b0, 8'hb2, 8'h3c, 8'h3c}, '{1'b0, 8'hb1, 8'hc8, 8'h08},
    '{1'b0, 8'h55, 8'h12, 8'h00}, '{1'b1, 8'h50, 8'h33, 8'h00}};
  int         divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic       sys_clk, rst, reg_io_space, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       reg_hit, cpu_status_word_i, wave_out_a, wave_out_b;
  logic [2:0] vector_ack, irq_req;
  int         mismatches, checked;
  ////////////////////////////////////////
  tmr2_timer #(.CNT_W(8)) uut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_io_space(reg_io_space), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .cpu_status_word_i(cpu_status_word_i),
    .vector_ack(vector_ack), .irq_req(irq_req),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
  ////////////////////////////////////////
  // Compare one value and count the outcome
  task automatic chk(input string what, input logic [7:0] seen, want);
    checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  // One-cycle write then an idle edge, so a strobe never flips twice at once
  task automatic wr(input logic io, input logic [7:0] a, v);
    reg_io_space = io;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : wr
  // One-cycle read; data is registered at the taking edge
  task automatic rd(input logic io, input logic [7:0] a, output logic [7:0] v);
    reg_io_space = io;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    v = reg_rdata;
    @(posedge sys_clk);
    #1;
  endtask : rd
  task automatic rc(input logic io, input logic [7:0] a, want, input string w);
    logic [7:0] v;
    rd(io, a, v);
    chk(w, v, want);
  endtask : rc
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Run undivided from a start count, then stop the clock again
  task automatic run(input logic [7:0] start, input int n);
    wr(1'b0, TMR2_OFS_COUNT, start);
    wr(1'b0, TMR2_OFS_CTRL2, 8'h01);
    tick(n);
    wr(1'b0, TMR2_OFS_CTRL2, 8'h00);
  endtask : run
  // Force strobes with the clock stopped, then look at both outputs
  task automatic frc(input logic [7:0] v, want, input string w);
    wr(1'b0, TMR2_OFS_CTRL2, v);
    tick(3);
    chk(w, {6'h0, wave_out_b, wave_out_a}, want);
  endtask : frc
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the longest run, about 6300 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  // Main sequence
  initial
  begin
    {rst, reg_io_space, reg_wr, reg_rd, cpu_status_word_i} = 5'h10;
    {reg_addr, reg_wdata, vector_ack} = '0;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    foreach (ROWS[i])
      rc(ROWS[i].io, ROWS[i].addr, 8'h00, "reset value");
    foreach (ROWS[i])
    begin
      wr(ROWS[i].io, ROWS[i].addr, ROWS[i].wd);
      rc(ROWS[i].io, ROWS[i].addr, ROWS[i].rd_exp, "row");
      chk("row hit", {7'h0, reg_hit},
          {7'h0, !ROWS[i].io && ROWS[i].addr != 8'h55});
    end
    rc(1'b0, TMR2_OFS_MASK, 8'h05, "mask after io write");
    // Every clock select code, four prescaled periods each, 40 cycles for the stop code
    for (int c = 0; c < 8; c++)
    begin
      wr(1'b0, TMR2_OFS_COUNT, 8'h00);
      wr(1'b0, TMR2_OFS_CTRL2, 8'(c));
      tick(c == 0 ? 40 : 4 * divs[c]);
      wr(1'b0, TMR2_OFS_CTRL2, 8'h00);
      rd(1'b0, TMR2_OFS_COUNT, d);
      if (c == 0)
        chk("stopped count", d, 8'h00);
      else
        chk("tick rate", {7'h0, d inside {[8'd3:8'd6]}}, 8'h01);
    end
    // Wrap through channel b match and overflow
    wr(1'b0, TMR2_OFS_CMP_B, 8'hfe);
    wr(1'b0, TMR2_OFS_MASK, 8'h07);
    run(8'hfa, 10);
    rc(1'b0, TMR2_OFS_FLAGS, 8'h05, "flags");
    chk("irq global off", {5'h0, irq_req}, 8'h00);
    cpu_status_word_i = 1'b1;
    #1 chk("irq on", {5'h0, irq_req}, 8'h05);
    wr(1'b0, TMR2_OFS_MASK, 8'h04);
    chk("irq masked", {5'h0, irq_req}, 8'h04);
    vector_ack = 3'h4;
    tick(1);
    vector_ack = 3'h0;
    chk("irq after vector", {5'h0, irq_req}, 8'h00);
    rc(1'b0, TMR2_OFS_FLAGS, 8'h01, "flags after vector");
    wr(1'b0, TMR2_OFS_MASK, 8'h00);
    run(8'hfa, 10);
    wr(1'b1, 8'h17, 8'h03);
    chk("io flag hit", {7'h0, reg_hit}, 8'h01);
    rc(1'b1, 8'h17, 8'h04, "zero keeps b flag");
    wr(1'b1, 8'h17, 8'h04);
    rc(1'b0, TMR2_OFS_FLAGS, 8'h00, "one clears b flag");
    // Count written onto the compare value while running
    wr(1'b0, TMR2_OFS_CMP_A, 8'h20);
    wr(1'b0, TMR2_OFS_CTRL2, 8'h01);
    wr(1'b0, TMR2_OFS_COUNT, 8'h20);
    tick(6);
    wr(1'b0, TMR2_OFS_CTRL2, 8'h00);
    rc(1'b0, TMR2_OFS_FLAGS, 8'h00, "match after count write");
    // Forced matches in clear-on-match mode, then in fast PWM
    wr(1'b0, TMR2_OFS_COUNT, 8'h42);
    wr(1'b0, TMR2_OFS_CTRL1, 8'h72);
    frc(8'hc0, 8'h03, "force toggle a set b");
    rc(1'b0, TMR2_OFS_FLAGS, 8'h00, "force flags");
    rc(1'b0, TMR2_OFS_COUNT, 8'h42, "force keeps count");
    wr(1'b0, TMR2_OFS_CTRL1, 8'h62);
    frc(8'h40, 8'h01, "force clear b");
    frc(8'h80, 8'h00, "force toggle a");
    tick(5);
    chk("one toggle", {6'h0, wave_out_b, wave_out_a}, 8'h00);
    frc(8'h80, 8'h01, "toggle back");
    wr(1'b0, TMR2_OFS_CTRL1, 8'ha3);
    frc(8'h00, 8'h01, "plain write in PWM");
    frc(8'h80, 8'h01, "force in PWM");
    // Reset in mid-run
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    chk("wave after reset", {6'h0, wave_out_b, wave_out_a}, 8'h00);
    chk("irq after reset", {5'h0, irq_req}, 8'h00);
    rc(1'b0, TMR2_OFS_COUNT, 8'h00, "count after reset");
    summarize();
  end
endmodule : tmr2_timer_tb_top
